// File: asrp_ctrl.sv
// Host controller driving an asynchronous 16-bit SRAM with ECC flag.
// Assumes one request at a time from logic on clk; pins are asynchronous.
`timescale 1ns/1ns
`include "asrp_cfg.svh"

module asrp_ctrl
   import asrp_pkg::*;
#(
   parameter int AW = `ASRP_ADDR_W,
   parameter int DW = `ASRP_DATA_W
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   // User request side
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   input  wire logic [1:0]    req_be,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   output logic               rsp_corrected,
   // Memory pins
   output logic               chip_select_a_n,
   output logic               chip_select_b,
   output logic               write_strobe_n,
   output logic               output_drive_n,
   output logic               upper_byte_strobe_n,
   output logic               lower_byte_strobe_n,
   output logic [AW-1:0]      mem_addr,
   output logic [DW-1:0]      data_o,
   output logic               data_oe,
   input  wire logic [DW-1:0] data_i,
   input  wire logic          err_i
);

   localparam logic [3:0] RD_LOAD = 4'(`ASRP_RD_CYC + `ASRP_SYNC_CYC - 1);
   localparam logic [3:0] WR_LOAD = 4'(`ASRP_WR_CYC - 1);

   asrp_state_e   state_q, state_d;
   logic [3:0]    cnt_q, cnt_d;
   logic          sel_q, sel_d;
   logic          we_n_q, we_n_d;
   logic          oe_n_q, oe_n_d;
   logic          ub_n_q, ub_n_d;
   logic          lb_n_q, lb_n_d;
   logic          wr_q, wr_d;
   logic [1:0]    be_q, be_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [DW-1:0] wdata_q, wdata_d;
   logic          doe_q, doe_d;
   logic          rsp_q, rsp_d;
   logic [DW-1:0] rdata_q, rdata_d;
   logic          corr_q, corr_d;
   logic [DW-1:0] data_sync;
   logic          err_sync;

   // Pin inputs pass two flip-flops before capture
   asrp_sync #(.W(DW + 1)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({err_i, data_i}),
      .dout  ({err_sync, data_sync})
   );

   // Sequencer next-state logic
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      sel_d   = sel_q;
      we_n_d  = we_n_q;
      oe_n_d  = oe_n_q;
      ub_n_d  = ub_n_q;
      lb_n_d  = lb_n_q;
      wr_d    = wr_q;
      be_d    = be_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      doe_d   = doe_q;
      rsp_d   = 1'b0;
      rdata_d = rdata_q;
      corr_d  = corr_q;
      unique case (state_q)
         ST_IDLE: begin
            if (req_valid) begin
               // Address settles a full cycle before select goes active
               addr_d  = req_addr;
               wdata_d = req_wdata;
               wr_d    = req_write;
               be_d    = (!req_write && req_be == 2'h0) ? 2'h3 : req_be;
               doe_d   = req_write;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP: begin
            sel_d  = 1'b1;
            lb_n_d = ~be_q[0];
            ub_n_d = ~be_q[1];
            if (wr_q) begin
               // Write strobe only with a lane strobe; output drive stays high
               we_n_d  = ~(|be_q);
               cnt_d   = WR_LOAD;
               state_d = ST_WRITE;
            end else begin
               oe_n_d  = 1'b0;
               cnt_d   = RD_LOAD;
               state_d = ST_READ;
            end
         end
         ST_WRITE: begin
            if (cnt_q == 4'h0) begin
               // All write controls go inactive together; data is still driven
               sel_d   = 1'b0;
               we_n_d  = 1'b1;
               ub_n_d  = 1'b1;
               lb_n_d  = 1'b1;
               state_d = ST_HOLD;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ST_HOLD: begin
            doe_d   = 1'b0;
            rsp_d   = 1'b1;
            state_d = ST_IDLE;
         end
         ST_READ: begin
            if (cnt_q == 4'h0) begin
               // Floated lanes read as zero; flag captured with the data
               rdata_d = data_sync & asrp_lane_mask(be_q);
               corr_d  = err_sync;
               rsp_d   = 1'b1;
               sel_d   = 1'b0;
               oe_n_d  = 1'b1;
               ub_n_d  = 1'b1;
               lb_n_d  = 1'b1;
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         sel_q   <= 1'b0;
         we_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         ub_n_q  <= 1'b1;
         lb_n_q  <= 1'b1;
         wr_q    <= 1'b0;
         be_q    <= 2'h0;
         addr_q  <= '0;
         wdata_q <= '0;
         doe_q   <= 1'b0;
         rsp_q   <= 1'b0;
         rdata_q <= '0;
         corr_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         sel_q   <= sel_d;
         we_n_q  <= we_n_d;
         oe_n_q  <= oe_n_d;
         ub_n_q  <= ub_n_d;
         lb_n_q  <= lb_n_d;
         wr_q    <= wr_d;
         be_q    <= be_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         doe_q   <= doe_d;
         rsp_q   <= rsp_d;
         rdata_q <= rdata_d;
         corr_q  <= corr_d;
      end
   end

   // Pin and response outputs
   assign chip_select_a_n     = ~sel_q;
   assign chip_select_b       = sel_q;
   assign write_strobe_n      = we_n_q;
   assign output_drive_n      = oe_n_q;
   assign upper_byte_strobe_n = ub_n_q;
   assign lower_byte_strobe_n = lb_n_q;
   assign mem_addr            = addr_q;
   assign data_o              = wdata_q;
   assign data_oe             = doe_q;
   assign req_ready           = (state_q == ST_IDLE);
   assign rsp_valid           = rsp_q;
   assign rsp_rdata           = rdata_q;
   assign rsp_corrected       = corr_q;

   // Helper: length of the current write strobe pulse
   logic [3:0] pulse_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 4'h0;
      end else begin
         pulse_q <= we_n_q ? 4'h0 : pulse_q + 4'h1;
      end
   end

   // Address is stable in the cycle select goes active
   chk_addr_before_sel: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(sel_q) |-> $stable(mem_addr))
      else $error("Address changed as select went active");

   // Write strobe low only with select and a lane strobe
   chk_write_overlap: assert property (@(posedge clk) disable iff (!rst_n)
      !write_strobe_n |-> (sel_q && !(upper_byte_strobe_n && lower_byte_strobe_n) && data_oe))
      else $error("Write strobe without select or lane strobe");

   // Data driven at the terminating edge and two cycles before, and stable since the cycle before
   chk_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(write_strobe_n) |-> data_oe && $stable(data_o) && $past(data_oe, 2))
      else $error("Write data not held around write end");

   // Output drive never low unless write strobe is high
   chk_read_we_high: assert property (@(posedge clk) disable iff (!rst_n)
      !output_drive_n |-> write_strobe_n && !data_oe)
      else $error("Write strobe or data drive active during read");

   // Write pulse spans the required cycles
   chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(write_strobe_n) |-> pulse_q >= 4'(`ASRP_WR_CYC))
      else $error("Write pulse too short");

   // Read answer arrives a fixed number of cycles after output drive falls
   chk_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(output_drive_n) |-> ##3 (rsp_q && !wr_q))
      else $error("Read answer not on time");

endmodule : asrp_ctrl

// File: asrp_cfg.svh
// Constants for the asynchronous SRAM port host controller.
// Assumes a 10 MHz system clock; all times are converted to cycles here.
//
// Functional notes
// - Address must be valid no later than the combined select going active.
// - Write happens only while write strobe, select and a byte strobe overlap.
// - Write data stays stable around the edge that ends the write.
// - Write strobe stays high throughout every read.
// - Write pulse lasts at least output turn-off time plus data setup time.
`ifndef ASRP_CFG_SVH
`define ASRP_CFG_SVH

`define ASRP_ADDR_W   18
`define ASRP_DATA_W   16
`define ASRP_CLK_NS   100
// Address/select to data and flag valid
`define ASRP_T_AA_NS  45
// Write pulse: larger of pulse width and turn-off plus setup
`define ASRP_T_HZWE_NS 18
`define ASRP_T_SD_NS   25
`define ASRP_T_PWE_NS  35
`define ASRP_T_WP_NS  ((`ASRP_T_HZWE_NS + `ASRP_T_SD_NS) > `ASRP_T_PWE_NS ? \
                       (`ASRP_T_HZWE_NS + `ASRP_T_SD_NS) : `ASRP_T_PWE_NS)
`define ASRP_RD_CYC   ((`ASRP_T_AA_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
`define ASRP_WR_CYC   ((`ASRP_T_WP_NS + `ASRP_CLK_NS - 1) / `ASRP_CLK_NS)
// Two synchroniser stages between the pins and the capture register
`define ASRP_SYNC_CYC 2

`endif

// File: asrp_pkg.sv
// Types for the asynchronous SRAM port host controller.
// Assumes asrp_cfg.svh is on the include path.
`include "asrp_cfg.svh"

package asrp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_READ,
      ST_WRITE,
      ST_HOLD
   } asrp_state_e;

   // Expands the two byte enables into a 16-bit lane mask
   function automatic logic [15:0] asrp_lane_mask(input logic [1:0] be);
      asrp_lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : asrp_lane_mask

endpackage : asrp_pkg

// File: asrp_sync.sv
// Two-stage synchroniser for inputs arriving from the memory pins.
// Assumes the pins are asynchronous to clk; only stage two is read outside.
`timescale 1ns/1ns

module asrp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule : asrp_sync

// File: asrp_sram_model.sv
// Behavioural model of the 16-bit static memory with byte lanes and correction flag.
// Assumes the bench resolves the shared data bus and feeds the level back on dq_i.
`timescale 1ns/1ns

module asrp_sram_model (
   input  wire logic [17:0] addr,
   input  wire logic        chip_select_a_n,
   input  wire logic        chip_select_b,
   input  wire logic        write_strobe_n,
   input  wire logic        output_drive_n,
   input  wire logic        upper_byte_strobe_n,
   input  wire logic        lower_byte_strobe_n,
   input  wire logic [15:0] dq_i,
   input  wire logic [17:0] flip_addr,
   input  wire logic        flip_en,
   output logic      [15:0] dq_o,
   output logic      [1:0]  dq_en,
   output logic             err_o,
   output logic             err_en
);
   logic [15:0] mem [0:262143];
   logic        sel;
   logic        rd;

   // Select decode and read lanes
   assign sel   = !chip_select_a_n && chip_select_b;
   assign rd    = sel && write_strobe_n && !output_drive_n;
   assign dq_en = {rd && !upper_byte_strobe_n, rd && !lower_byte_strobe_n};
   assign dq_o  = mem[addr];

   // Flag only during a driven read; stored data is returned already corrected
   assign err_en = rd && (|dq_en);
   assign err_o  = flip_en && (addr == flip_addr);

   // Level write: stores only while all controls overlap, stops when any goes inactive
   always @* begin
      if (sel && !write_strobe_n) begin
         if (!lower_byte_strobe_n) mem[addr][7:0] = dq_i[7:0];
         if (!upper_byte_strobe_n) mem[addr][15:8] = dq_i[15:8];
      end
   end
endmodule : asrp_sram_model

// File: tb.sv
// Self-checking bench for the static memory host controller.
// Assumes asrp_pkg and the memory model are compiled first; 10 MHz clock.
`timescale 1ns/1ns

module tb;
   import asrp_pkg::*;
   logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, flt_q = 0, flip_en = 0;
   logic [17:0] req_addr = 0, flip_addr = 0, mem_addr;
   logic [15:0] req_wdata = 0, data_o, data_i, dq_o, lane_drv;
   logic [1:0]  req_be = 0, dq_en;
   logic req_ready, rsp_valid, rsp_corrected, cs_a_n, cs_b, we_n, oe_n, ubs_n, lbs_n;
   logic data_oe, err_o, err_en, err_i;
   logic [15:0] rsp_rdata;
   int          err_count = 0, cmp_count = 0, cyc = 0;

   // Clock and a float pattern that changes every cycle
   always #50 clk = ~clk;
   always @(posedge clk) flt_q <= ~flt_q;

   // Bus resolution between controller, memory and undriven lines
   assign lane_drv = {{8{dq_en[1]}}, {8{dq_en[0]}}};
   assign data_i   = data_oe ? data_o : ((lane_drv & dq_o) | (~lane_drv & {16{flt_q}}));
   assign err_i    = err_en ? err_o : flt_q;

   asrp_ctrl DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_corrected(rsp_corrected),
      .chip_select_a_n(cs_a_n), .chip_select_b(cs_b), .write_strobe_n(we_n),
      .output_drive_n(oe_n), .upper_byte_strobe_n(ubs_n), .lower_byte_strobe_n(lbs_n),
      .mem_addr(mem_addr), .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .err_i(err_i));

   asrp_sram_model mem_model (.addr(mem_addr), .chip_select_a_n(cs_a_n), .chip_select_b(cs_b),
      .write_strobe_n(we_n), .output_drive_n(oe_n), .upper_byte_strobe_n(ubs_n),
      .lower_byte_strobe_n(lbs_n), .dq_i(data_i), .flip_addr(flip_addr), .flip_en(flip_en),
      .dq_o(dq_o), .dq_en(dq_en), .err_o(err_o), .err_en(err_en));

   task automatic chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      chk_word(nm, {15'h0000, exp}, {15'h0000, got});
   endtask : chk_bit

   task automatic results;
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results

   // Pin watch: no contention, write strobe idle while output drive is on
   always @(negedge clk) begin
      if (rst_n && !oe_n) chk_bit("we_in_read", 1'b1, we_n);
      if (rst_n && data_oe) chk_word("contention", 16'h0000, {14'h0000, dq_en});
   end

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         results();
      end
   end

   // One request, checked for answer latency
   task automatic op(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be,
                     input logic [15:0] lat);
      logic [15:0] n;
      @(negedge clk);
      {req_valid, req_write, req_addr, req_wdata, req_be} = {1'b1, wr, a, d, be};
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 0;
      n = 16'h0001;
      while (rsp_valid !== 1'b1 && n < 16'h0014) begin
         @(negedge clk);
         n++;
      end
      chk_word("latency", lat, n);
   endtask : op

   task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
      op(1'b1, a, d, be, 16'h0004);
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [1:0] be, input logic [15:0] e, input logic c);
      op(1'b0, a, 16'h0000, be, 16'h0005);
      chk_word("rdata", e, rsp_rdata);
      chk_bit("corrected", c, rsp_corrected);
   endtask : rd

   task automatic t_idle;
      chk_word("idle_pins", 16'h005F, {9'h000, cs_a_n, cs_b, we_n, oe_n, ubs_n, lbs_n, req_ready});
   endtask : t_idle

   task automatic t_full;
      wr(18'h3FFFF, 16'hA5C3, 2'b11);
      wr(18'h00000, 16'h5A3C, 2'b11);
      rd(18'h3FFFF, 2'b11, 16'hA5C3, 1'b0);
      rd(18'h00000, 2'b00, 16'h5A3C, 1'b0);
   endtask : t_full

   task automatic t_byte;
      wr(18'h00001, 16'h1234, 2'b11);
      wr(18'h00001, 16'hABFF, 2'b10);
      wr(18'h00001, 16'hFFCD, 2'b01);
      wr(18'h00001, 16'h0000, 2'b00);
      rd(18'h00001, 2'b11, 16'hABCD, 1'b0);
      rd(18'h00001, 2'b01, 16'h00CD, 1'b0);
      rd(18'h00001, 2'b10, 16'hAB00, 1'b0);
   endtask : t_byte

   task automatic t_err;
      flip_addr = 18'h00001;
      flip_en   = 1'b1;
      rd(18'h00001, 2'b11, 16'hABCD, 1'b1);
      rd(18'h3FFFF, 2'b11, 16'hA5C3, 1'b0);
      rd(18'h00001, 2'b10, 16'hAB00, 1'b1);
      flip_en = 1'b0;
   endtask : t_err

   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1;
      t_idle();
      t_full();
      t_byte();
      t_err();
      results();
   end
endmodule : tb
